/* File: hdl/cpu_priority_level_pkg.sv */
// Package: register map, field layout and types for the CPU priority level block
package cpu_priority_level_pkg;

  // ==========================================================================
  // Register offsets (word addresses on the plain register port)
  localparam logic [3:0] STATUS_OFFSET   = 4'h0;  // cpu_status_reg
  localparam logic [3:0] CORE_CTL_OFFSET = 4'h1;  // core_control_reg
  localparam logic [3:0] INT_CTL1_OFFSET = 4'h2;  // interrupt_control_reg1
  localparam logic [3:0] LEVEL_OFFSET    = 4'h3;  // effective level, read only

  // ==========================================================================
  // Field positions
  localparam int PRIO_LSB        = 5;   // cpu_status_reg[7:5]
  localparam int PRIO_MSB        = 7;
  localparam int CORE_HIGH_BIT   = 3;   // core_control_reg[3]
  localparam int NEST_DIS_BIT    = 15;  // interrupt_control_reg1[15]

  // ==========================================================================
  // Reset values and codes
  localparam logic [15:0] STATUS_RESET   = 16'h0000;
  localparam logic [15:0] CORE_CTL_RESET = 16'h0000;
  localparam logic [15:0] INT_CTL1_RESET = 16'h0000;
  localparam logic [2:0]  PRIO_TOP_CODE  = 3'h7;  // Blocks user interrupts

  // ==========================================================================
  // Types
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [3:0]  addr;
    logic [15:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic        high_bit;  // Extra high-order level bit
    logic [2:0]  field;     // Three-bit status field
  } level_t;

endpackage : cpu_priority_level_pkg

/* File: hdl/cpu_priority_level_status.sv */
// Top: CPU status priority field, core control high bit, nesting disable and level decode
//
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
// What this block does
// - The three-bit status field is binary, codes 000 to 111 giving levels 0 to 7 when the high bit is clear.
// - The effective level is the core control high bit placed above the field, so 8 to 15 when it is set.
// - Field code 111 means level 7 or 15 and no user interrupt is accepted.
// - A set high-order level bit disables all user interrupts whatever the field holds.
// - While nesting disable is set, software writes to the field are ignored and it reads as read-only.
module cpu_priority_level_status (
  // Clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        rstn_in,
  // Register port
  input  wire logic [3:0]  reg_addr_in,
  input  wire logic [15:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic [15:0]      reg_rdata_out,
  // Core side: level update from exception processing
  input  wire logic        core_level_load_in,
  input  wire logic [2:0]  core_level_in,
  // Decoded level
  output logic [3:0]       cpu_priority_level_out,
  output logic             user_irq_block_out,
  output logic             nesting_disable_out
);

  // ==========================================================================
  // Register map
  // Word addresses on the register port:
  //   0 cpu_status_reg, [7:5] priority field, the other bits plain storage
  //   1 core_control_reg, [3] extra high-order level bit, the other bits storage
  //   2 interrupt_control_reg1, [15] nesting disable, the other bits storage
  //   3 effective level, read only, [3:0] level and [4] user interrupt block
  // Other offsets read zero and drop writes. The port never stalls: a write
  // lands at its strobe edge and a read answers in the next cycle only.

  // ==========================================================================
  // Registers
  // Bus request and level carriers
  cpu_priority_level_pkg::reg_req_t req;
  cpu_priority_level_pkg::level_t   lvl;
  // Register state
  logic [15:0] status_q;
  logic [15:0] core_ctl_q;
  logic [15:0] int_ctl1_q;
  logic [15:0] rdata_q;
  // Decode results and write strobes
  logic [3:0]  level_w;
  logic        block_w;
  logic        wr_status;
  logic        nest_dis;

  assign req       = '{wr: reg_wr_in, rd: reg_rd_in, addr: reg_addr_in, wdata: reg_wdata_in};
  assign nest_dis  = int_ctl1_q[cpu_priority_level_pkg::NEST_DIS_BIT];
  assign wr_status = req.wr && (req.addr == cpu_priority_level_pkg::STATUS_OFFSET);

  // ==========================================================================
  // Status register; the field is locked against software under nesting disable.
  // The core's own level load still lands, since hardware must raise the level.
  // Bits outside the field are plain storage here and take every write whole.
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      status_q <= cpu_priority_level_pkg::STATUS_RESET;
    end else begin
      if (wr_status) begin
        status_q[cpu_priority_level_pkg::PRIO_LSB-1:0] <= req.wdata[cpu_priority_level_pkg::PRIO_LSB-1:0];
        status_q[15:cpu_priority_level_pkg::PRIO_MSB+1] <= req.wdata[15:cpu_priority_level_pkg::PRIO_MSB+1];
        if (!nest_dis) begin
          status_q[cpu_priority_level_pkg::PRIO_MSB:cpu_priority_level_pkg::PRIO_LSB] <=
            req.wdata[cpu_priority_level_pkg::PRIO_MSB:cpu_priority_level_pkg::PRIO_LSB];
        end
      end
      // Core update wins over a software write in the same cycle
      if (core_level_load_in) begin
        status_q[cpu_priority_level_pkg::PRIO_MSB:cpu_priority_level_pkg::PRIO_LSB] <= core_level_in;
      end
    end
  end

  // Core control register
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      core_ctl_q <= cpu_priority_level_pkg::CORE_CTL_RESET;
    end else if (req.wr && (req.addr == cpu_priority_level_pkg::CORE_CTL_OFFSET)) begin
      core_ctl_q <= req.wdata;
    end
  end

  // Interrupt control register 1
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      int_ctl1_q <= cpu_priority_level_pkg::INT_CTL1_RESET;
    end else if (req.wr && (req.addr == cpu_priority_level_pkg::INT_CTL1_OFFSET)) begin
      int_ctl1_q <= req.wdata;
    end
  end

  // ==========================================================================
  // Level decode
  assign lvl.high_bit = core_ctl_q[cpu_priority_level_pkg::CORE_HIGH_BIT];
  assign lvl.field    = status_q[cpu_priority_level_pkg::PRIO_MSB:cpu_priority_level_pkg::PRIO_LSB];

  level_decode u_decode (
    .lvl_in         (lvl),
    .level_out      (level_w),
    .user_block_out (block_w)
  );

  // ==========================================================================
  // Decoded outputs registered so they trail the registers by one cycle.
  // The extra cycle keeps them free of glitches when the field and the high
  // bit change in the same cycle; a user of the block must allow for it.
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cpu_priority_level_out <= 4'h0;
      user_irq_block_out     <= 1'b0;
      nesting_disable_out    <= 1'b0;
    end else begin
      cpu_priority_level_out <= level_w;
      user_irq_block_out     <= block_w;
      nesting_disable_out    <= nest_dis;
    end
  end

  // ==========================================================================
  // Read data, one cycle after the strobe; unmapped reads return zero
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_q <= 16'h0000;
    end else if (req.rd) begin
      case (req.addr)
        cpu_priority_level_pkg::STATUS_OFFSET:   rdata_q <= status_q;
        cpu_priority_level_pkg::CORE_CTL_OFFSET: rdata_q <= core_ctl_q;
        cpu_priority_level_pkg::INT_CTL1_OFFSET: rdata_q <= int_ctl1_q;
        cpu_priority_level_pkg::LEVEL_OFFSET:    rdata_q <= {11'h000, block_w, level_w};
        default:                                 rdata_q <= 16'h0000;
      endcase
    end else begin
      rdata_q <= 16'h0000;
    end
  end
  assign reg_rdata_out = rdata_q;

  // ==========================================================================
  // Checks
  AST_FIELD_LOCKED: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    (wr_status && nest_dis && !core_level_load_in) |=> $stable(lvl.field))
    else $error("Priority field changed while nesting disable set");

  AST_FIELD_WRITTEN: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    (wr_status && !nest_dis && !core_level_load_in) |=> (lvl.field == $past(req.wdata[7:5])))
    else $error("Priority field write lost");

  AST_LEVEL_CONCAT: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    ##1 1'b1 |-> (cpu_priority_level_out == {$past(lvl.high_bit), $past(lvl.field)}))
    else $error("Effective level not formed from high bit and field");

  AST_LOW_RANGE: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    (!lvl.high_bit) |=> (cpu_priority_level_out <= 4'h7))
    else $error("Level above 7 with high bit clear");

  AST_HIGH_RANGE: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    (lvl.high_bit) |=> (cpu_priority_level_out >= 4'h8))
    else $error("Level below 8 with high bit set");

  AST_TOP_BLOCKS: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    (lvl.field == 3'h7) |=> user_irq_block_out)
    else $error("Top field code did not block user interrupts");

  AST_HIGH_BLOCKS: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    (lvl.high_bit) |=> user_irq_block_out)
    else $error("High level bit did not block user interrupts");

  AST_NO_FALSE_BLOCK: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    (!lvl.high_bit && lvl.field != 3'h7) |=> !user_irq_block_out)
    else $error("User interrupts blocked below top level");

  AST_TOP_LEVEL_VALUE: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    (lvl.field == 3'h7) |=> (cpu_priority_level_out[2:0] == 3'h7))
    else $error("Top field code did not give level 7 or 15");

  AST_LOW_END: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    (!lvl.high_bit && (lvl.field == 3'h0)) |=> (cpu_priority_level_out == 4'h0))
    else $error("Field code zero with high bit clear did not give level 0");

  AST_HIGH_END: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    (lvl.high_bit && (lvl.field == 3'h0)) |=> (cpu_priority_level_out == 4'h8))
    else $error("Field code zero with high bit set did not give level 8");

  // ==========================================================================
  // Checks on writes, the core load and the nesting control
  AST_CORE_LOAD_WINS: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    core_level_load_in |=> (lvl.field == $past(core_level_in)))
    else $error("Core level load did not land in the priority field");

  AST_OTHER_BITS_WRITTEN: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    wr_status |=> ((status_q[4:0] == $past(req.wdata[4:0])) && (status_q[15:8] == $past(req.wdata[15:8]))))
    else $error("Status bits outside the field lost a write");

  AST_FIELD_HOLDS: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    (!wr_status && !core_level_load_in) |=> $stable(lvl.field))
    else $error("Priority field changed with no write and no core load");

  AST_HIGH_BIT_WRITTEN: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    (req.wr && (req.addr == cpu_priority_level_pkg::CORE_CTL_OFFSET)) |=>
      (lvl.high_bit == $past(req.wdata[cpu_priority_level_pkg::CORE_HIGH_BIT])))
    else $error("High-order level bit did not follow a core control write");

  AST_NEST_FOLLOWS: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    1'b1 |=> (nesting_disable_out == $past(nest_dis)))
    else $error("Nesting disable output does not follow its control bit");

  // ==========================================================================
  // Checks on the read port
  AST_READ_STATUS: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    (req.rd && (req.addr == cpu_priority_level_pkg::STATUS_OFFSET)) |=>
      (reg_rdata_out == $past(status_q)))
    else $error("Status read did not return the register");

  AST_READ_LEVEL: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    (req.rd && (req.addr == cpu_priority_level_pkg::LEVEL_OFFSET)) |=>
      ((reg_rdata_out[3:0] == cpu_priority_level_out) && (reg_rdata_out[4] == user_irq_block_out)
       && (reg_rdata_out[15:5] == 11'h000)))
    else $error("Level read disagrees with the decoded outputs");

endmodule : cpu_priority_level_status

/* File: hdl/level_decode.sv */
// Leaf: forms the four-bit level and the user interrupt block flag
`timescale 1ns/1ps
module level_decode (
  // Level inputs
  input  wire cpu_priority_level_pkg::level_t lvl_in,
  // Decoded outputs
  output logic [3:0]                          level_out,
  output logic                                user_block_out
);

  // Concatenate high-order bit above the field
  assign level_out      = {lvl_in.high_bit, lvl_in.field};
  // Top field code or high-order bit blocks user interrupts
  assign user_block_out = (lvl_in.field == cpu_priority_level_pkg::PRIO_TOP_CODE)
                          | lvl_in.high_bit;

endmodule : level_decode

/* File: verif/tb_cpu_priority_level_status.sv */
// Testbench: register access, level decode and nesting lock of the priority level block
`timescale 1ns/1ps
module tb_cpu_priority_level_status;
  // ==========================================================================
  // Signals and offsets
  localparam logic [3:0] a_st   = cpu_priority_level_pkg::STATUS_OFFSET;
  localparam logic [3:0] a_core = cpu_priority_level_pkg::CORE_CTL_OFFSET;
  localparam logic [3:0] a_ictl = cpu_priority_level_pkg::INT_CTL1_OFFSET;
  localparam logic [3:0] a_lvl  = cpu_priority_level_pkg::LEVEL_OFFSET;
  logic        ref_clk_in;
  logic        rstn_in;
  logic [3:0]  reg_addr_in;
  logic [15:0] reg_wdata_in;
  logic        reg_wr_in;
  logic        reg_rd_in;
  logic [15:0] reg_rdata_out;
  logic        core_level_load_in;
  logic [2:0]  core_level_in;
  logic [3:0]  cpu_priority_level_out;
  logic        user_irq_block_out;
  logic        nesting_disable_out;
  int          num_errors;
  int          n_tests;

  // Device under test
  cpu_priority_level_status uut (.ref_clk_in, .rstn_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
    .reg_rdata_out, .core_level_load_in, .core_level_in, .cpu_priority_level_out, .user_irq_block_out,
    .nesting_disable_out);

  // 50 MHz clock
  initial begin
    ref_clk_in = 1'b0;
    forever #10 ref_clk_in = ~ref_clk_in;
  end

  // ==========================================================================
  // Tasks
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One-cycle write strobe; the slave never stalls
  task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk_in);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_wr_in    <= 1'b1;
    @(posedge ref_clk_in);
    reg_wr_in    <= 1'b0;
  endtask : reg_write

  // Read data stand only in the cycle after the strobe, so look there
  task automatic reg_read(input logic [3:0] a, input logic [15:0] exp);
    @(posedge ref_clk_in);
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    @(posedge ref_clk_in);
    reg_rd_in   <= 1'b0;
    #1;
    chk("reg_rdata_out", exp, reg_rdata_out);
    // Read data stand one cycle only, then fall back to zero
    @(posedge ref_clk_in);
    #1;
    chk("reg_rdata_out idle", 16'h0000, reg_rdata_out);
  endtask : reg_read

  // Decoded outputs lag the registers by one cycle; two edges leave margin
  task automatic check_level(input logic [3:0] lvl);
    logic blk;
    blk = lvl[3] | (lvl[2:0] == cpu_priority_level_pkg::PRIO_TOP_CODE);
    repeat (2) @(posedge ref_clk_in);
    #1;
    chk("cpu_priority_level_out", {12'h000, lvl}, {12'h000, cpu_priority_level_out});
    chk("user_irq_block_out", {15'h0000, blk}, {15'h0000, user_irq_block_out});
    reg_read(a_lvl, {11'h000, blk, lvl});
  endtask : check_level

  task automatic test_done;
    $display("Checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done

  // Watchdog against a hung run
  initial begin
    #1000000;
    num_errors++;
    test_done;
  end

  // ==========================================================================
  // Main sequence
  initial begin
    rstn_in = 1'b0;
    reg_addr_in = 4'h0;
    reg_wdata_in = 16'h0000;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    core_level_load_in = 1'b0;
    core_level_in = 3'h0;
    num_errors = 0;
    n_tests = 0;
    repeat (3) @(posedge ref_clk_in);
    rstn_in <= 1'b1;
    reg_read(a_st, cpu_priority_level_pkg::STATUS_RESET);
    reg_read(a_core, cpu_priority_level_pkg::CORE_CTL_RESET);
    reg_read(a_ictl, cpu_priority_level_pkg::INT_CTL1_RESET);
    // Every field code, first with the high bit clear, then set
    for (int h = 0; h < 2; h++) begin
      reg_write(a_core, h[0] ? 16'h0008 : 16'h0000);
      for (int c = 0; c < 8; c++) begin
        reg_write(a_st, {8'h00, c[2:0], 5'h00});
        reg_read(a_st, {8'h00, c[2:0], 5'h00});
        check_level({h[0], c[2:0]});
      end
    end
    // Nesting lock: field keeps its value, other bits still take the write
    reg_write(a_core, 16'h0000);
    reg_write(a_st, 16'h0040);
    reg_write(a_ictl, 16'h8000);
    check_level(4'h2);
    chk("nesting_disable_out", 16'h0001, {15'h0000, nesting_disable_out});
    reg_write(a_st, 16'h00ff);
    reg_read(a_st, 16'h005f);
    check_level(4'h2);
    // Core load stays open under the lock
    @(posedge ref_clk_in);
    core_level_load_in <= 1'b1;
    core_level_in      <= 3'h7;
    @(posedge ref_clk_in);
    core_level_load_in <= 1'b0;
    check_level(4'h7);
    reg_read(a_st, 16'h00ff);
    // Lock lifted: the field is writable again
    reg_write(a_ictl, 16'h0000);
    reg_write(a_st, 16'h0020);
    check_level(4'h1);
    chk("nesting_disable_out", 16'h0000, {15'h0000, nesting_disable_out});
    // Core load and software write in one cycle: the core value takes the field
    @(posedge ref_clk_in);
    reg_addr_in        <= a_st;
    reg_wdata_in       <= 16'h00e0;
    reg_wr_in          <= 1'b1;
    core_level_load_in <= 1'b1;
    core_level_in      <= 3'h3;
    @(posedge ref_clk_in);
    reg_wr_in          <= 1'b0;
    core_level_load_in <= 1'b0;
    check_level(4'h3);
    reg_read(a_st, 16'h0060);
    // Unmapped offset reads zero and a write there is dropped
    reg_write(4'h9, 16'hffff);
    reg_read(4'h9, 16'h0000);
    reg_read(a_st, 16'h0060);
    // Reset in mid-run: outputs and registers fall back to their reset values
    reg_write(a_core, 16'h0008);
    reg_write(a_ictl, 16'h8000);
    check_level(4'hb);
    @(posedge ref_clk_in);
    rstn_in <= 1'b0;
    #1;
    chk("cpu_priority_level_out", 16'h0000, {12'h000, cpu_priority_level_out});
    chk("user_irq_block_out", 16'h0000, {15'h0000, user_irq_block_out});
    chk("nesting_disable_out", 16'h0000, {15'h0000, nesting_disable_out});
    repeat (2) @(posedge ref_clk_in);
    rstn_in <= 1'b1;
    reg_read(a_core, cpu_priority_level_pkg::CORE_CTL_RESET);
    reg_read(a_ictl, cpu_priority_level_pkg::INT_CTL1_RESET);
    reg_read(a_st, cpu_priority_level_pkg::STATUS_RESET);
    check_level(4'h0);
    test_done;
  end
endmodule : tb_cpu_priority_level_status
